// File: common/dcs_cfg.svh
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// ==========================================================
// Register byte offsets
`define DCS_OFS_DIVIDER 12'h0500
`define DCS_OFS_OUTPUT 12'h0504
`define DCS_OFS_CONTROL 12'h0508
`define DCS_OFS_AUX 12'h0538

// ==========================================================
// Writable bit masks
`define DCS_MASK_DIVIDER 32'h0000_FFFF
`define DCS_MASK_OUTPUT 32'h0000_000F
`define DCS_MASK_CONTROL 32'h0000_FFFF
`define DCS_MASK_AUX 32'h0000_0001

// ==========================================================
// Reset values
`define DCS_RST_DIVIDER 32'h0000_0081
`define DCS_RST_OUTPUT 32'h0000_000A
`define DCS_RST_CONTROL 32'h0000_3F89
`define DCS_RST_AUX 32'h0000_0000

// ==========================================================
// Divider register fields
`define DCS_FB_MSB 15
`define DCS_FB_LSB 6
`define DCS_FB_SS_MSB 12
`define DCS_REF_MSB 5
`define DCS_REF_LSB 0

// ==========================================================
// Output register fields
`define DCS_HOLD_BIT 3
`define DCS_OUTDIV_MSB 2
`define DCS_OUTDIV_LSB 0

// ==========================================================
// Control register fields
`define DCS_PD_BIT 15
`define DCS_FSE_BIT 14
`define DCS_AV_BIT 13
`define DCS_CV_BIT 12
`define DCS_BYP_BIT 11
`define DCS_LCNT_MSB 10
`define DCS_LCNT_LSB 7
`define DCS_LWIN_MSB 6
`define DCS_LWIN_LSB 4
`define DCS_FILT_MSB 3
`define DCS_FILT_LSB 0

// ==========================================================
// Auxiliary register fields
`define DCS_SSE_BIT 0
`define DCS_LOCK_BIT 8
`define DCS_DETECT_BIT 9

// ==========================================================
// Lock figures
`define DCS_LOCK_EXP_BASE 5
`define DCS_LOCK_WIN_BASE_PPM 17'd500

`endif

// File: common/dcs_pkg.sv
package dcs_pkg;

  // ==========================================================
  // Output divider codes
  typedef enum logic [2:0] {
    DCS_OUT_DIV1 = 3'b000,
    DCS_OUT_DIV2 = 3'b001,
    DCS_OUT_DIV4 = 3'b010,
    DCS_OUT_DIV8 = 3'b011,
    DCS_OUT_DIV16 = 3'b100,
    DCS_OUT_DIV32 = 3'b101
  } dcs_out_div_e;

  // ==========================================================
  // APB answer phases
  typedef enum logic [1:0] {
    DCS_APB_IDLE = 2'b00,
    DCS_APB_WAIT = 2'b01,
    DCS_APB_DONE = 2'b10
  } dcs_apb_e;

  typedef logic [31:0] dcs_word_t;

  // Field value plus one, widened by one bit
  function automatic logic [10:0] dcs_plus_one(input logic [9:0] v);
    dcs_plus_one = {1'b0, v} + 11'd1;
  endfunction : dcs_plus_one

  // Power of two of a small exponent
  function automatic logic [20:0] dcs_pow2(input logic [4:0] e);
    dcs_pow2 = 21'd1 << e;
  endfunction : dcs_pow2

endpackage : dcs_pkg

// File: hdl/dcs_sync2.sv
`timescale 1ns/1ns

// ==========================================================
// Two-flop synchroniser
module dcs_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Asynchronous level in
  input wire logic [W-1:0] async_in,
  // Synchronised level out
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : dcs_sync2

// File: hdl/dcs_lock_timer.sv
`timescale 1ns/1ns

// ==========================================================
// Lock qualification counter
module dcs_lock_timer
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Qualifiers
  input wire logic ref_tick,
  input wire logic lock_seen,
  input wire logic clear,
  input wire logic [20:0] target,
  // Lock result
  output logic locked
);

  logic [20:0] cnt_ff;
  logic locked_ff;

  // Count reference cycles while detection holds
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (clear || !lock_seen) begin
      cnt_ff <= '0;
      locked_ff <= 1'b0;
    end else if (ref_tick && !locked_ff) begin
      if (cnt_ff + 21'd1 >= target) begin
        locked_ff <= 1'b1;
      end
      cnt_ff <= cnt_ff + 21'd1;
    end
  end

  assign locked = locked_ff;

endmodule : dcs_lock_timer

// File: hdl/dcs_synth_config.sv
`timescale 1ns/1ns
`include "dcs_cfg.svh"

// Notes on behaviour
// - Feedback divide is field plus one, 1..1024
// - Spread mode uses seven low bits, 1..128
// - Reference divide is field plus one
// - Hold bit keeps synthesizer in reset, except in bypass or power-down
// - Output divide codes select powers of two
// - Power-down overrides bypass, hold, feedback select, spread and lock, all low; core off high
// - Feedback select: 0 pin, 1 internal
// - External feedback makes spread mode ineffective
// - Core voltage bit: 1 high, 0 low
// - Bypass powers core down, passes reference
// - Lock delay is two to count plus five
// - Lock window doubles from 500 ppm
// - Registers read-write, aux lock and detect bits read-only, reset by bus reset

module dcs_synth_config
  import dcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Synthesizer pins
  input wire logic reference_clock_in,
  input wire logic synth_lock_detect,
  output logic [10:0] fb_divide_ratio,
  output logic [6:0] ref_divide_ratio,
  output logic [5:0] out_divide_ratio,
  output logic synth_hold_reset,
  output logic synth_power_down,
  output logic synth_core_off,
  output logic synth_bypass,
  output logic feedback_path_select,
  output logic spread_spectrum_enable,
  output logic core_voltage_select,
  output logic analog_voltage_select,
  output logic [3:0] filter_range,
  output logic [3:0] lock_count_field,
  output logic [16:0] lock_window_ppm,
  output logic synth_locked
);

  // ==========================================================
  // Register storage
  dcs_word_t divider_cfg_ff;
  dcs_word_t output_cfg_ff;
  dcs_word_t control_cfg_ff;
  dcs_word_t aux_cfg_ff;

  // ==========================================================
  // Bus state
  dcs_apb_e apb_state_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  logic nxt_hit;
  logic wr_take;

  // ==========================================================
  // Pin synchronisation
  logic ref_sync;
  logic detect_sync;
  logic ref_prev_ff;
  logic ref_tick;
  logic lock_raw;

  // ==========================================================
  // Decoded fields
  logic pd_bit;
  logic fse_bit;
  logic byp_bit;
  logic hold_bit;
  logic sse_eff;
  logic [2:0] out_code;
  logic [10:0] nxt_fb_ratio;
  logic [5:0] nxt_out_ratio;
  logic [20:0] lock_target;

  // Byte-lane merge of a write into a stored word
  function automatic dcs_word_t merge_write(
    input dcs_word_t old_v,
    input dcs_word_t new_v,
    input logic [3:0] strb,
    input dcs_word_t mask
  );
    dcs_word_t tmp;
    tmp = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        tmp[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_write = tmp & mask;
  endfunction : merge_write

  // ==========================================================
  // Address decode and read mux
  always_comb begin
    nxt_hit = 1'b1;
    nxt_prdata = 32'h0000_0000;
    if (paddr == `DCS_OFS_DIVIDER) begin
      nxt_prdata = divider_cfg_ff;
    end else if (paddr == `DCS_OFS_OUTPUT) begin
      nxt_prdata = output_cfg_ff;
    end else if (paddr == `DCS_OFS_CONTROL) begin
      nxt_prdata = control_cfg_ff;
    end else if (paddr == `DCS_OFS_AUX) begin
      nxt_prdata = aux_cfg_ff;
      nxt_prdata[`DCS_LOCK_BIT] = synth_locked;
      nxt_prdata[`DCS_DETECT_BIT] = detect_sync;
    end else begin
      nxt_hit = 1'b0;
    end
  end

  // Write commits at the edge that samples pready high
  assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff;

  // ==========================================================
  // APB answer: one wait cycle, then pready for one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      apb_state_ff <= DCS_APB_IDLE;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      case (apb_state_ff)
        DCS_APB_IDLE: begin
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
          if (psel && penable) begin
            apb_state_ff <= DCS_APB_WAIT;
            pready_ff <= 1'b1;
            pslverr_ff <= !nxt_hit;
            prdata_ff <= (pwrite || !nxt_hit) ? 32'h0000_0000 : nxt_prdata;
          end
        end
        DCS_APB_WAIT: begin
          apb_state_ff <= DCS_APB_DONE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
        DCS_APB_DONE: begin
          apb_state_ff <= DCS_APB_IDLE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
        default: begin
          apb_state_ff <= DCS_APB_IDLE;
          pready_ff <= 1'b0;
          pslverr_ff <= 1'b0;
        end
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================
  // Divider register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_cfg_ff <= `DCS_RST_DIVIDER;
    end else if (wr_take && paddr == `DCS_OFS_DIVIDER) begin
      divider_cfg_ff <= merge_write(divider_cfg_ff, pwdata, pstrb, `DCS_MASK_DIVIDER);
    end
  end

  // Output register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_cfg_ff <= `DCS_RST_OUTPUT;
    end else if (wr_take && paddr == `DCS_OFS_OUTPUT) begin
      output_cfg_ff <= merge_write(output_cfg_ff, pwdata, pstrb, `DCS_MASK_OUTPUT);
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_cfg_ff <= `DCS_RST_CONTROL;
    end else if (wr_take && paddr == `DCS_OFS_CONTROL) begin
      control_cfg_ff <= merge_write(control_cfg_ff, pwdata, pstrb, `DCS_MASK_CONTROL);
    end
  end

  // Auxiliary register holding spread enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aux_cfg_ff <= `DCS_RST_AUX;
    end else if (wr_take && paddr == `DCS_OFS_AUX) begin
      aux_cfg_ff <= merge_write(aux_cfg_ff, pwdata, pstrb, `DCS_MASK_AUX);
    end
  end

  // ==========================================================
  // Field decode
  assign pd_bit = control_cfg_ff[`DCS_PD_BIT];
  assign fse_bit = control_cfg_ff[`DCS_FSE_BIT];
  assign byp_bit = control_cfg_ff[`DCS_BYP_BIT];
  assign hold_bit = output_cfg_ff[`DCS_HOLD_BIT];
  assign sse_eff = aux_cfg_ff[`DCS_SSE_BIT] && fse_bit;
  assign out_code = output_cfg_ff[`DCS_OUTDIV_MSB:`DCS_OUTDIV_LSB];

  // Feedback ratio, short field in spread mode
  always_comb begin
    if (sse_eff) begin
      nxt_fb_ratio = dcs_plus_one({3'b000, divider_cfg_ff[`DCS_FB_SS_MSB:`DCS_FB_LSB]});
    end else begin
      nxt_fb_ratio = dcs_plus_one(divider_cfg_ff[`DCS_FB_MSB:`DCS_FB_LSB]);
    end
  end

  // Output ratio, unused codes clamp to the deepest divide
  always_comb begin
    case (out_code)
      DCS_OUT_DIV1: nxt_out_ratio = 6'd1;
      DCS_OUT_DIV2: nxt_out_ratio = 6'd2;
      DCS_OUT_DIV4: nxt_out_ratio = 6'd4;
      DCS_OUT_DIV8: nxt_out_ratio = 6'd8;
      DCS_OUT_DIV16: nxt_out_ratio = 6'd16;
      default: nxt_out_ratio = 6'd32;
    endcase
  end

  // Lock delay in reference cycles
  assign lock_target = dcs_pow2(5'(control_cfg_ff[`DCS_LCNT_MSB:`DCS_LCNT_LSB])
    + 5'(`DCS_LOCK_EXP_BASE));

  // ==========================================================
  // Registered ratios and voltages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_divide_ratio <= 11'd3;
      ref_divide_ratio <= 7'd2;
      out_divide_ratio <= 6'd4;
      core_voltage_select <= 1'b1;
      analog_voltage_select <= 1'b1;
      filter_range <= 4'h9;
      lock_count_field <= 4'hF;
      lock_window_ppm <= `DCS_LOCK_WIN_BASE_PPM;
    end else begin
      fb_divide_ratio <= nxt_fb_ratio;
      ref_divide_ratio <= 7'(dcs_plus_one({4'h0,
        divider_cfg_ff[`DCS_REF_MSB:`DCS_REF_LSB]}));
      out_divide_ratio <= nxt_out_ratio;
      core_voltage_select <= control_cfg_ff[`DCS_CV_BIT];
      analog_voltage_select <= control_cfg_ff[`DCS_AV_BIT];
      filter_range <= control_cfg_ff[`DCS_FILT_MSB:`DCS_FILT_LSB];
      lock_count_field <= control_cfg_ff[`DCS_LCNT_MSB:`DCS_LCNT_LSB];
      lock_window_ppm <= `DCS_LOCK_WIN_BASE_PPM
        << control_cfg_ff[`DCS_LWIN_MSB:`DCS_LWIN_LSB];
    end
  end

  // ==========================================================
  // Registered power, bypass and reset with precedence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_power_down <= 1'b0;
      synth_core_off <= 1'b1;
      synth_bypass <= 1'b1;
      synth_hold_reset <= 1'b0;
      feedback_path_select <= 1'b0;
      spread_spectrum_enable <= 1'b0;
    end else begin
      synth_power_down <= pd_bit;
      synth_core_off <= pd_bit || byp_bit;
      synth_bypass <= byp_bit && !pd_bit;
      synth_hold_reset <= hold_bit && !byp_bit && !pd_bit;
      feedback_path_select <= fse_bit && !pd_bit;
      spread_spectrum_enable <= sse_eff && !pd_bit;
    end
  end

  // ==========================================================
  // Pin synchronisers
  dcs_sync2 #(
    .W(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .async_in({reference_clock_in, synth_lock_detect}),
    .sync_out({ref_sync, detect_sync})
  );

  // Reference rising edge from synchronised level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_prev_ff <= 1'b0;
    end else begin
      ref_prev_ff <= ref_sync;
    end
  end

  assign ref_tick = ref_sync && !ref_prev_ff;

  // ==========================================================
  // Lock qualification, cleared while core is off or held
  dcs_lock_timer u_lock (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ref_tick(ref_tick),
    .lock_seen(detect_sync),
    .clear(pd_bit || byp_bit || hold_bit),
    .target(lock_target),
    .locked(lock_raw)
  );

  // Lock output from its own flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      synth_locked <= 1'b0;
    end else begin
      synth_locked <= lock_raw && !pd_bit;
    end
  end

endmodule : dcs_synth_config

// File: test/dcs_synth_config_properties.sv
`timescale 1ns/1ns

// ==========================================================
// Checker on bus answer and synthesizer controls
module dcs_synth_config_properties (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Synthesizer controls
  input wire logic [10:0] fb_divide_ratio,
  input wire logic [5:0] out_divide_ratio,
  input wire logic synth_hold_reset,
  input wire logic synth_power_down,
  input wire logic synth_core_off,
  input wire logic synth_bypass,
  input wire logic feedback_path_select,
  input wire logic spread_spectrum_enable,
  input wire logic [16:0] lock_window_ppm,
  input wire logic synth_locked
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Core running and out of reset
  wire logic core_run = !synth_core_off && !synth_hold_reset;

  a_bus_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_fb_range: assert property (fb_divide_ratio inside {[1:1024]})
    else $error("feedback ratio out of range");
  a_spread_range: assert property (spread_spectrum_enable |-> fb_divide_ratio <= 128)
    else $error("spread feedback ratio above 128");
  a_out_pow2: assert property (out_divide_ratio inside {1, 2, 4, 8, 16, 32})
    else $error("output ratio not a power of two");
  a_pd_wins: assert property (synth_power_down |-> synth_core_off && !synth_bypass
    && !feedback_path_select && !spread_spectrum_enable && !synth_hold_reset)
    else $error("power-down not overriding");
  a_byp_over_rst: assert property (synth_bypass |-> synth_core_off && !synth_hold_reset)
    else $error("bypass not over reset");
  a_sse_gated: assert property (spread_spectrum_enable |-> feedback_path_select)
    else $error("spread active with pin feedback");
  a_win_codes: assert property (lock_window_ppm inside
    {500, 1000, 2000, 4000, 8000, 16000, 32000, 64000})
    else $error("lock window not a listed value");
  a_lock_drop: assert property (!core_run [*3] |-> !synth_locked)
    else $error("lock held while core stopped");
  a_lock_rise: assert property ($rose(synth_locked) |-> $past(core_run, 2))
    else $error("lock rose while core stopped");

  // Main scenarios
  c_locked: cover property ($rose(synth_locked));
  c_slverr: cover property (pslverr);
  c_spread: cover property (spread_spectrum_enable);
endmodule : dcs_synth_config_properties

bind dcs_synth_config dcs_synth_config_properties chk (.sys_clk, .rst_n, .psel, .penable,
  .pready, .pslverr, .fb_divide_ratio, .out_divide_ratio, .synth_hold_reset,
  .synth_power_down, .synth_core_off, .synth_bypass, .feedback_path_select,
  .spread_spectrum_enable, .lock_window_ppm, .synth_locked);

// File: test/dcs_synth_model.sv
`timescale 1ns/1ns

// ==========================================================
// Analog synthesizer stand-in
module dcs_synth_model #(
  parameter int REF_HALF_NS = 40
) (
  // Bench control
  input wire logic lock_req,
  // Controls from the block
  input wire logic synth_core_off,
  input wire logic synth_hold_reset,
  // Pins to the block
  output logic reference_clock_in,
  output logic synth_lock_detect
);
  // Free-running reference oscillator
  initial reference_clock_in = 1'b0;
  always #(REF_HALF_NS) reference_clock_in = ~reference_clock_in;
  // Detect only while the core runs out of reset
  assign synth_lock_detect = lock_req && !synth_core_off && !synth_hold_reset;
endmodule : dcs_synth_model

// File: test/dcs_synth_config_tb.sv
`timescale 1ns/1ns
`include "dcs_cfg.svh"

// ==========================================================
// Bench for the synthesizer configuration bank
module dcs_synth_config_tb
  import dcs_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, reference_clock_in, synth_lock_detect, lock_req = 1'b0;
  logic [10:0] fb_divide_ratio;
  logic [6:0] ref_divide_ratio;
  logic [5:0] out_divide_ratio;
  logic synth_hold_reset, synth_power_down, synth_core_off, synth_bypass;
  logic feedback_path_select, spread_spectrum_enable, core_voltage_select;
  logic analog_voltage_select, synth_locked;
  logic [3:0] filter_range, lock_count_field;
  logic [16:0] lock_window_ppm;
  int n_fail = 0;
  int comparisons = 0;

  // System clock
  always #5 sys_clk = ~sys_clk;

  dcs_synth_config uut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reference_clock_in, .synth_lock_detect, .fb_divide_ratio,
    .ref_divide_ratio, .out_divide_ratio, .synth_hold_reset, .synth_power_down,
    .synth_core_off, .synth_bypass, .feedback_path_select, .spread_spectrum_enable,
    .core_voltage_select, .analog_voltage_select, .filter_range, .lock_count_field,
    .lock_window_ppm, .synth_locked);

  dcs_synth_model model (.lock_req, .synth_core_off, .synth_hold_reset, .reference_clock_in,
    .synth_lock_detect);

  // Verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer, then idle gap
  task automatic apb(input logic [11:0] a, input logic w, input dcs_word_t d,
                     output dcs_word_t q, output logic e);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    // Wait for the answer; only the watchdog ends a hang
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : apb

  // Write, error not expected
  task automatic wr(input logic [11:0] a, input dcs_word_t d);
    dcs_word_t q;
    logic e;
    apb(a, 1'b1, d, q, e);
    chk("wr_err", 32'h0000_0000, 32'(e));
  endtask : wr

  // Read and compare data and error
  task automatic rd(input logic [11:0] a, input dcs_word_t x, input logic xe);
    dcs_word_t q;
    logic e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    chk("rdata", x, q);
    chk("rd_err", 32'(xe), 32'(e));
  endtask : rd

  // Reference edges, then realign to system clock
  task automatic ref_wait(input int n);
    repeat (n) @(posedge reference_clock_in);
    @(posedge sys_clk);
  endtask : ref_wait

  // Watchdog
  initial begin
    #300000;
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    dcs_word_t q;
    logic e;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`DCS_OFS_DIVIDER, 32'h0000_0081, 1'b0);
    rd(`DCS_OFS_OUTPUT, 32'h0000_000A, 1'b0);
    rd(`DCS_OFS_CONTROL, 32'h0000_3F89, 1'b0);
    chk("fb", 32'd3, 32'(fb_divide_ratio));
    chk("ref", 32'd2, 32'(ref_divide_ratio));
    chk("out", 32'd4, 32'(out_divide_ratio));
    chk("byp", 32'd1, 32'(synth_bypass));
    chk("hold", 32'd0, 32'(synth_hold_reset));
    chk("cv", 32'd1, 32'(core_voltage_select));
    chk("fse", 32'd0, 32'(feedback_path_select));
    chk("lcnt", 32'hF, 32'(lock_count_field));
    chk("win", 32'd500, 32'(lock_window_ppm));
    chk("av", 32'd1, 32'(analog_voltage_select));
    chk("filt", 32'h9, 32'(filter_range));
    // Divider extremes, reserved bits written back as read
    wr(`DCS_OFS_DIVIDER, 32'h0000_FFFF);
    rd(`DCS_OFS_DIVIDER, 32'h0000_FFFF, 1'b0);
    chk("fb", 32'd1024, 32'(fb_divide_ratio));
    chk("ref", 32'd64, 32'(ref_divide_ratio));
    wr(`DCS_OFS_DIVIDER, 32'h0000_0000);
    chk("fb", 32'd1, 32'(fb_divide_ratio));
    chk("ref", 32'd1, 32'(ref_divide_ratio));
    // Low byte lane only
    pstrb <= 4'h1;
    wr(`DCS_OFS_DIVIDER, 32'h0000_FFFF);
    pstrb <= 4'hF;
    rd(`DCS_OFS_DIVIDER, 32'h0000_00FF, 1'b0);
    chk("fb", 32'd4, 32'(fb_divide_ratio));
    // Every output divider code, held and bypassed so divide-by-one is safe
    for (int k = 0; k < 6; k++) begin
      wr(`DCS_OFS_OUTPUT, 32'h0000_0008 | 32'(k));
      chk("out", 32'd1 << k, 32'(out_divide_ratio));
    end
    wr(`DCS_OFS_OUTPUT, 32'h0000_000E);
    chk("out", 32'd32, 32'(out_divide_ratio));
    // Every lock window code, bypass off so hold shows
    for (int k = 0; k < 8; k++) begin
      wr(`DCS_OFS_CONTROL, 32'h0000_3789 | (32'(k) << 4));
      chk("win", 32'd500 << k, 32'(lock_window_ppm));
    end
    chk("hold", 32'd1, 32'(synth_hold_reset));
    wr(`DCS_OFS_OUTPUT, 32'h0000_0005);
    chk("hold", 32'd0, 32'(synth_hold_reset));
    wr(`DCS_OFS_CONTROL, 32'h0000_2789);
    chk("cv", 32'd0, 32'(core_voltage_select));
    // Spread mode with pin, then internal feedback
    wr(`DCS_OFS_DIVIDER, 32'h0000_FFC0);
    wr(`DCS_OFS_AUX, 32'h0000_0001);
    chk("sse", 32'd0, 32'(spread_spectrum_enable));
    chk("fb", 32'd1024, 32'(fb_divide_ratio));
    wr(`DCS_OFS_CONTROL, 32'h0000_7789);
    chk("fse", 32'd1, 32'(feedback_path_select));
    chk("sse", 32'd1, 32'(spread_spectrum_enable));
    chk("fb", 32'd128, 32'(fb_divide_ratio));
    // Lock after 32 then 64 reference edges
    wr(`DCS_OFS_CONTROL, 32'h0000_7009);
    chk("lcnt", 32'h0, 32'(lock_count_field));
    lock_req <= 1'b1;
    ref_wait(24);
    chk("lock", 32'd0, 32'(synth_locked));
    ref_wait(16);
    chk("lock", 32'd1, 32'(synth_locked));
    lock_req <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("lock", 32'd0, 32'(synth_locked));
    wr(`DCS_OFS_CONTROL, 32'h0000_7089);
    lock_req <= 1'b1;
    ref_wait(56);
    chk("lock", 32'd0, 32'(synth_locked));
    ref_wait(16);
    chk("lock", 32'd1, 32'(synth_locked));
    rd(`DCS_OFS_AUX, 32'h0000_0301, 1'b0);
    // Power-down over bypass and feedback select
    wr(`DCS_OFS_CONTROL, 32'h0000_F889);
    chk("pd", 32'd1, 32'(synth_power_down));
    chk("byp", 32'd0, 32'(synth_bypass));
    chk("fse", 32'd0, 32'(feedback_path_select));
    chk("off", 32'd1, 32'(synth_core_off));
    chk("lock", 32'd0, 32'(synth_locked));
    // Unmapped address refused
    apb(12'h05FC, 1'b1, 32'hFFFF_FFFF, q, e);
    chk("uw_err", 32'd1, 32'(e));
    rd(12'h05FC, 32'h0000_0000, 1'b1);
    // Mid-run reset restores values
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(`DCS_OFS_CONTROL, 32'h0000_3F89, 1'b0);
    rd(`DCS_OFS_DIVIDER, 32'h0000_0081, 1'b0);
    conclude();
  end
endmodule : dcs_synth_config_tb
